// ---- verilog/homing_regs.svh ----
// Encodings, pin indices and timing constants of the homing sequencer
`ifndef HOMING_REGS_SVH
`define HOMING_REGS_SVH

`define SRC_OFF        3'h0
`define SRC_DI         3'h1
`define SRC_PANEL      3'h2
`define SRC_COMM       3'h3
`define SRC_FIRST_ON   3'h4

`define MODE_POS_LIMIT 4'h0
`define MODE_NEG_LIMIT 4'h1
`define MODE_ORG_RISE_F 4'h2
`define MODE_ORG_RISE_B 4'h3
`define MODE_ORG_FALL_F 4'h4
`define MODE_ORG_FALL_B 4'h5
`define MODE_Z_F       4'h6
`define MODE_Z_B       4'h7
`define MODE_HERE      4'h8

`define POL_Z_REV      3'h0
`define POL_Z_FWD      3'h1
`define POL_Z_NONE     3'h2
`define POL_STOP_REV   3'h3
`define POL_STOP_FWD   3'h4
`define POL_STOP_NONE  3'h5

`define PIN_START      0
`define PIN_ORG        1
`define PIN_DECEL      2
`define PIN_Z          3
`define PIN_PLIM       4
`define PIN_NLIM       5
`define PIN_COUNT      6

`define CLK_HZ         32'h0131_2D00
`define MS_PER_S       32'h0000_03E8

`define SPEED_ZERO     16'h0000
`define POS_ZERO       32'h0000_0000
`define ONE_POS        32'h0000_0001
`define TIME_ZERO      16'h0000

`endif

// ---- verilog/homing_pkg.sv ----
// Types shared by the homing sequencer modules
package homing_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FAST  = 3'h1,
    ST_SLOW  = 3'h2,
    ST_ZSRCH = 3'h3,
    ST_OFFS  = 3'h4,
    ST_STOP  = 3'h5,
    ST_DONE  = 3'h6,
    ST_ALARM = 3'h7
  } home_state_e;

  typedef logic [15:0] speed_t;
  typedef logic [31:0] pos_t;

endpackage : homing_pkg

// ---- verilog/ramp_if.sv ----
// Speed ramp request and result between sequencer and ramp generator
`timescale 1ns/100ps
interface ramp_if;
  homing_pkg::speed_t target;
  homing_pkg::speed_t rate;
  logic [15:0]        ramp_time;
  homing_pkg::speed_t speed;

  modport ramp (input target, input rate, input ramp_time, output speed);
  modport ctrl (output target, output rate, output ramp_time, input speed);
endinterface : ramp_if

// ---- verilog/pin_sync.sv ----
// Two-flop synchronisers with edge detection for a vector of pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] last_ff;

  // Edges are taken from the second stage only, never the metastable first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;
endmodule : pin_sync

// ---- verilog/speed_ramp.sv ----
// Linear speed ramp: full search speed is reached in the ramp time
`timescale 1ns/100ps
`include "homing_regs.svh"
module speed_ramp #(
  parameter int CYC_PER_MS = 20000
) (
  input  wire logic clk,
  input  wire logic rst,
  ramp_if.ramp      r
);
  logic [31:0] span;
  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;

  // Span in cycles; one unit of speed per crossing of the span
  assign span    = 32'(r.ramp_time) * 32'(CYC_PER_MS);
  assign nxt_acc = acc_ff + 32'(r.rate);

  // Limitation: at most one speed unit per cycle, ample at this clock rate
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_ff  <= `POS_ZERO;
      r.speed <= `SPEED_ZERO;
    end
    else if (r.ramp_time == `TIME_ZERO || r.speed == r.target)
    begin
      acc_ff  <= `POS_ZERO;
      r.speed <= r.target;
    end
    else if (nxt_acc >= span)
    begin
      acc_ff  <= nxt_acc - span;
      r.speed <= (r.speed < r.target) ? r.speed + 16'h0001 : r.speed - 16'h0001;
    end
    else
    begin
      acc_ff <= nxt_acc;
    end
  end
endmodule : speed_ramp

// ---- verilog/servo_homing_sequencer.sv ----
// Homing sequencer top: start selection, reference search, origin load and offset move
//
// Functional notes
// - Start source 0 off, 1 start input, 2 panel, 3 communication command.
// - Start source 4 starts homing once at the first servo-on.
// - Mode 0 forward to positive limit, mode 1 backward to negative limit.
// - Modes 2/3 forward/backward, origin sensor off-to-on edge is the reference.
// - Modes 4/5 forward/backward, origin sensor on-to-off edge is the reference.
// - Modes 6/7 forward/backward, nearest Z pulse is the origin.
// - Mode 8 takes present position as origin without searching.
// - Policy 0 reverse Z search, 1 forward Z search, 2 no Z search.
// - Policies 3/4/5 stop and alarm on limit contact, same Z behaviour.
// - Modes 0 and 1 never stop or alarm on limit contact.
// - Z search follows limit contact in modes 0/1, sensor in 2..5.
// - Homing starts toward the high search speed in modes 0..5, the low search speed in modes 6/7.
// - Switch to low speed at reference or deceleration point.
// - Start and stop ramps use the search ramp time in ms.
// - Origin not found within time limit raises timeout alarm and stops.
// - Origin found loads absolute position with coordinate offset.
// - After origin, move further by the mechanical offset.
// - Optional deceleration sensor input is accepted.
// - Homing completion output is provided.
`timescale 1ns/100ps
`include "homing_regs.svh"
module servo_homing_sequencer #(
  parameter int CYC_PER_MS = int'(`CLK_HZ / `MS_PER_S)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          homing_start_input,
  input  wire logic          panel_start,
  input  wire logic          comm_start,
  input  wire logic          servo_on,
  input  wire logic          origin_sensor_input,
  input  wire logic          decel_sensor_input,
  input  wire logic          zphase_input,
  input  wire logic          pos_limit_input,
  input  wire logic          neg_limit_input,
  input  wire logic          enc_step,
  input  wire logic          enc_forward,
  input  wire logic [2:0]    homing_start_source,
  input  wire logic [3:0]    homing_reference_mode,
  input  wire logic [2:0]    limit_zphase_policy,
  input  wire logic [15:0]   search_high_speed,
  input  wire logic [15:0]   search_low_speed,
  input  wire logic [15:0]   search_ramp_time,
  input  wire logic [15:0]   homing_time_limit,
  input  wire logic [31:0]   coordinate_offset,
  input  wire logic [31:0]   mechanical_offset,
  output logic [15:0]        speed_cmd_ff,
  output logic               forward_ff,
  output logic               busy_ff,
  output logic               origin_found_ff,
  output logic               homing_done_ff,
  output logic               homing_timeout_alarm_ff,
  output logic               limit_alarm_ff,
  output logic [31:0]        abs_position_ff
);
  homing_pkg::home_state_e state_ff;
  homing_pkg::home_state_e nxt_state;
  logic [3:0]              mode_ff;
  logic [2:0]              policy_ff;
  logic                    nxt_forward;
  homing_pkg::speed_t      tgt_ff;
  homing_pkg::speed_t      nxt_tgt;
  logic                    servo_on_q_ff;
  logic                    first_on_done_ff;
  logic [31:0]             tick_cnt_ff;
  logic [15:0]             ms_cnt_ff;
  homing_pkg::pos_t        off_cnt_ff;
  homing_pkg::pos_t        off_mag;
  logic [`PIN_COUNT-1:0]   lvl;
  logic [`PIN_COUNT-1:0]   rise;
  logic [`PIN_COUNT-1:0]   fall;
  logic                    start_req;
  logic                    start_ok;
  logic                    limit_hit;
  logic                    ref_hit;
  logic                    searching;
  logic                    timeout;
  logic                    z_rev;
  logic                    z_none;
  logic                    stop_on_limit;
  logic                    origin_evt;
  logic                    timeout_evt;
  logic                    limit_evt;
  logic                    done_evt;

  ramp_if u_rif ();

  pin_sync #(
    .WIDTH (`PIN_COUNT)
  ) u_sync (
    .clk    (clk),
    .rst    (rst),
    .pin_in ({neg_limit_input, pos_limit_input, zphase_input,
              decel_sensor_input, origin_sensor_input, homing_start_input}),
    .level  (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  // Ramp both starting and stopping of every move
  assign u_rif.target    = tgt_ff;
  assign u_rif.rate      = search_high_speed;
  assign u_rif.ramp_time = search_ramp_time;

  speed_ramp #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_ramp (
    .clk (clk),
    .rst (rst),
    .r   (u_rif.ramp)
  );

  // Start trigger selection
  always_comb
  begin
    case (homing_start_source)
      `SRC_DI:       start_req = rise[`PIN_START];
      `SRC_PANEL:    start_req = panel_start;
      `SRC_COMM:     start_req = comm_start;
      `SRC_FIRST_ON: start_req = servo_on & ~servo_on_q_ff & ~first_on_done_ff;
      default:       start_req = 1'b0;
    endcase
  end

  assign start_ok = start_req && homing_reference_mode <= `MODE_HERE &&
                    (state_ff == homing_pkg::ST_IDLE || state_ff == homing_pkg::ST_DONE ||
                     state_ff == homing_pkg::ST_ALARM);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      servo_on_q_ff    <= 1'b0;
      first_on_done_ff <= 1'b0;
    end
    else
    begin
      servo_on_q_ff <= servo_on;
      if (servo_on && !servo_on_q_ff)
        first_on_done_ff <= 1'b1;
    end
  end

  // Reference and policy decode
  assign limit_hit = forward_ff ? lvl[`PIN_PLIM] : lvl[`PIN_NLIM];
  assign z_rev  = (policy_ff == `POL_Z_REV) || (policy_ff == `POL_STOP_REV);
  assign z_none = (policy_ff == `POL_Z_NONE) || (policy_ff == `POL_STOP_NONE);
  assign stop_on_limit = policy_ff >= `POL_STOP_REV;
  assign off_mag = mechanical_offset[31] ? (`POS_ZERO - mechanical_offset) : mechanical_offset;

  always_comb
  begin
    case (mode_ff)
      `MODE_POS_LIMIT, `MODE_NEG_LIMIT:   ref_hit = limit_hit;
      `MODE_ORG_RISE_F, `MODE_ORG_RISE_B: ref_hit = rise[`PIN_ORG];
      `MODE_ORG_FALL_F, `MODE_ORG_FALL_B: ref_hit = fall[`PIN_ORG];
      default:                            ref_hit = 1'b0;
    endcase
  end

  // Homing time limit, zero disables it
  assign searching = state_ff == homing_pkg::ST_FAST || state_ff == homing_pkg::ST_SLOW ||
                     state_ff == homing_pkg::ST_ZSRCH;
  assign timeout = searching && homing_time_limit != `TIME_ZERO &&
                   ms_cnt_ff >= homing_time_limit;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_ff <= `POS_ZERO;
      ms_cnt_ff   <= `TIME_ZERO;
    end
    else if (start_ok)
    begin
      tick_cnt_ff <= `POS_ZERO;
      ms_cnt_ff   <= `TIME_ZERO;
    end
    else if (searching)
    begin
      if (tick_cnt_ff == 32'(CYC_PER_MS - 1))
      begin
        tick_cnt_ff <= `POS_ZERO;
        if (ms_cnt_ff != 16'hFFFF)
          ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      end
      else
      begin
        tick_cnt_ff <= tick_cnt_ff + `ONE_POS;
      end
    end
  end

  // Sequencing
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_forward = forward_ff;
    nxt_tgt     = tgt_ff;
    origin_evt  = 1'b0;
    timeout_evt = 1'b0;
    limit_evt   = 1'b0;
    done_evt    = 1'b0;
    case (state_ff)
      homing_pkg::ST_IDLE, homing_pkg::ST_DONE, homing_pkg::ST_ALARM:
      begin
        nxt_tgt = `SPEED_ZERO;
        if (start_ok)
        begin
          nxt_forward = ~homing_reference_mode[0];
          if (homing_reference_mode == `MODE_HERE)
            origin_evt = 1'b1;
          else if (homing_reference_mode >= `MODE_Z_F)
          begin
            nxt_state = homing_pkg::ST_ZSRCH;
            nxt_tgt   = search_low_speed;
          end
          else
          begin
            nxt_state = homing_pkg::ST_FAST;
            nxt_tgt   = search_high_speed;
          end
        end
      end
      homing_pkg::ST_FAST, homing_pkg::ST_SLOW:
      begin
        if (timeout)
          timeout_evt = 1'b1;
        else if (ref_hit)
        begin
          if (z_none)
            origin_evt = 1'b1;
          else
          begin
            nxt_state   = homing_pkg::ST_ZSRCH;
            nxt_forward = z_rev ? ~forward_ff : forward_ff;
            nxt_tgt     = search_low_speed;
          end
        end
        else if (limit_hit && mode_ff > `MODE_NEG_LIMIT)
        begin
          if (stop_on_limit)
            limit_evt = 1'b1;
          else
            nxt_forward = ~forward_ff;
        end
        else if (state_ff == homing_pkg::ST_FAST && rise[`PIN_DECEL])
        begin
          nxt_state = homing_pkg::ST_SLOW;
          nxt_tgt   = search_low_speed;
        end
      end
      homing_pkg::ST_ZSRCH:
      begin
        if (timeout)
          timeout_evt = 1'b1;
        else if (rise[`PIN_Z])
          origin_evt = 1'b1;
        else if (limit_hit && mode_ff > `MODE_NEG_LIMIT)
        begin
          if (stop_on_limit)
            limit_evt = 1'b1;
          else
            nxt_forward = ~forward_ff;
        end
      end
      homing_pkg::ST_OFFS:
      begin
        if (off_cnt_ff >= off_mag)
        begin
          nxt_state = homing_pkg::ST_STOP;
          nxt_tgt   = `SPEED_ZERO;
        end
      end
      homing_pkg::ST_STOP:
      begin
        nxt_tgt = `SPEED_ZERO;
        if (u_rif.speed == `SPEED_ZERO)
        begin
          nxt_state = homing_pkg::ST_DONE;
          done_evt  = 1'b1;
        end
      end
      default:
        nxt_state = homing_pkg::ST_IDLE;
    endcase
    if (origin_evt)
    begin
      nxt_state   = (off_mag == `POS_ZERO) ? homing_pkg::ST_STOP : homing_pkg::ST_OFFS;
      nxt_forward = ~mechanical_offset[31];
      nxt_tgt     = (off_mag == `POS_ZERO) ? `SPEED_ZERO : search_low_speed;
    end
    if (timeout_evt || limit_evt)
    begin
      nxt_state = homing_pkg::ST_ALARM;
      nxt_tgt   = `SPEED_ZERO;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= homing_pkg::ST_IDLE;
      forward_ff <= 1'b1;
      tgt_ff     <= `SPEED_ZERO;
      mode_ff    <= `MODE_POS_LIMIT;
      policy_ff  <= `POL_Z_REV;
    end
    else
    begin
      state_ff   <= nxt_state;
      forward_ff <= nxt_forward;
      tgt_ff     <= nxt_tgt;
      if (start_ok)
      begin
        mode_ff   <= homing_reference_mode;
        policy_ff <= limit_zphase_policy;
      end
    end
  end

  // Offset travel counter, counts encoder steps after the origin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      off_cnt_ff <= `POS_ZERO;
    else if (origin_evt)
      off_cnt_ff <= `POS_ZERO;
    else if (state_ff == homing_pkg::ST_OFFS && enc_step)
      off_cnt_ff <= off_cnt_ff + `ONE_POS;
  end

  // Absolute position counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      abs_position_ff <= `POS_ZERO;
    else if (origin_evt)
      abs_position_ff <= coordinate_offset;
    else if (enc_step)
      abs_position_ff <= enc_forward ? abs_position_ff + `ONE_POS
                                     : abs_position_ff - `ONE_POS;
  end

  // Status outputs; a new start clears completion and alarms
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      speed_cmd_ff            <= `SPEED_ZERO;
      busy_ff                 <= 1'b0;
      origin_found_ff         <= 1'b0;
      homing_done_ff          <= 1'b0;
      homing_timeout_alarm_ff <= 1'b0;
      limit_alarm_ff          <= 1'b0;
    end
    else
    begin
      speed_cmd_ff    <= u_rif.speed;
      busy_ff         <= nxt_state != homing_pkg::ST_IDLE && nxt_state != homing_pkg::ST_DONE &&
                         nxt_state != homing_pkg::ST_ALARM;
      origin_found_ff <= origin_evt;
      if (done_evt)
        homing_done_ff <= 1'b1;
      else if (start_ok)
        homing_done_ff <= 1'b0;
      if (timeout_evt)
        homing_timeout_alarm_ff <= 1'b1;
      else if (start_ok)
        homing_timeout_alarm_ff <= 1'b0;
      if (limit_evt)
        limit_alarm_ff <= 1'b1;
      else if (start_ok)
        limit_alarm_ff <= 1'b0;
    end
  end
endmodule : servo_homing_sequencer

// ---- verif/servo_homing_sequencer_assertions.sv ----
// Port-level assertions for the homing sequencer
`timescale 1ns/100ps
`include "homing_regs.svh"
module servo_homing_sequencer_assertions #(
  parameter int CYC_PER_MS = 20000
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        panel_start,
  input wire logic        comm_start,
  input wire logic [2:0]  homing_start_source,
  input wire logic [3:0]  homing_reference_mode,
  input wire logic [15:0] search_high_speed,
  input wire logic [15:0] search_ramp_time,
  input wire logic [15:0] homing_time_limit,
  input wire logic [31:0] coordinate_offset,
  input wire logic [15:0] speed_cmd_ff,
  input wire logic        forward_ff,
  input wire logic        busy_ff,
  input wire logic        origin_found_ff,
  input wire logic        homing_done_ff,
  input wire logic        homing_timeout_alarm_ff,
  input wire logic        limit_alarm_ff,
  input wire logic [31:0] abs_position_ff
);
  logic        go;
  logic        gentle;
  logic [31:0] busy_cnt_ff;
  assign go = !busy_ff && homing_reference_mode <= `MODE_HERE &&
    ((homing_start_source == `SRC_COMM && comm_start) ||
     (homing_start_source == `SRC_PANEL && panel_start));
  // One unit a cycle at most holds for any nonzero ramp time; gentle asks for a longer ramp
  assign gentle = 32'(search_high_speed) <= 32'(search_ramp_time) * CYC_PER_MS;
  // Starts from the pin or servo-on never clear it, so the bound only loosens
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_cnt_ff <= 32'h0000_0000;
    else if (go)
      busy_cnt_ff <= 32'h0000_0000;
    else if (busy_ff)
      busy_cnt_ff <= busy_cnt_ff + 32'h0000_0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_start_taken: assert property (go |=> busy_ff)
    else $error("start not taken");
  a_start_clears: assert property (go |=> !homing_done_ff && !homing_timeout_alarm_ff
    && !limit_alarm_ff)
    else $error("start left a status set");
  a_refused_idle: assert property (!busy_ff && (homing_start_source == `SRC_OFF ||
    homing_reference_mode > `MODE_HERE) |=> !busy_ff)
    else $error("refused start began homing");
  a_here_origin: assert property (go && homing_reference_mode == `MODE_HERE |=>
    origin_found_ff && abs_position_ff == coordinate_offset)
    else $error("present position not taken as origin");
  a_start_dir: assert property ($rose(busy_ff)
    && homing_reference_mode < `MODE_HERE |-> forward_ff == !homing_reference_mode[0])
    else $error("wrong search direction");
  a_done_sticky: assert property (homing_done_ff ##1 !busy_ff |-> homing_done_ff)
    else $error("completion dropped");
  a_done_still: assert property ($rose(homing_done_ff) |-> !busy_ff
    && speed_cmd_ff == 16'h0000)
    else $error("completion while moving");
  a_speed_cap: assert property (busy_ff |-> speed_cmd_ff <= search_high_speed)
    else $error("speed above high search speed");
  a_ramp_slope: assert property (busy_ff && gentle |=>
    speed_cmd_ff <= $past(speed_cmd_ff) + 16'h0001
    && speed_cmd_ff + 16'h0001 >= $past(speed_cmd_ff))
    else $error("speed step too large");
  a_limit_free: assert property (busy_ff && homing_reference_mode <= `MODE_NEG_LIMIT
    |=> !limit_alarm_ff)
    else $error("limit alarm in limit mode");
  a_timeout_late: assert property ($rose(homing_timeout_alarm_ff) |-> !busy_ff &&
    busy_cnt_ff >= (32'(homing_time_limit) - 1) * CYC_PER_MS)
    else $error("timeout alarm too early");
  c_done: cover property ($rose(homing_done_ff));
  c_timeout: cover property ($rose(homing_timeout_alarm_ff));
  c_limit: cover property ($rose(limit_alarm_ff));
  c_found: cover property (origin_found_ff);
endmodule : servo_homing_sequencer_assertions

// ---- verif/axis_model.sv ----
// Machine model: axis position, limits, origin sensor, Z marks and encoder steps
`timescale 1ns/100ps
module axis_model #(
  parameter int START = 10,
  parameter int DEC_LO = 50,
  parameter int ORG_LO = 100,
  parameter int ORG_HI = 200,
  parameter int LIM = 300,
  parameter int ZPITCH = 64
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        slow,
  input wire logic [15:0] speed_cmd_ff,
  input wire logic        forward_ff,
  output logic            enc_step,
  output logic            enc_forward,
  output logic            origin_sensor_input,
  output logic            decel_sensor_input,
  output logic            zphase_input,
  output logic            pos_limit_input,
  output logic            neg_limit_input
);
  int   pos;
  logic tick;
  // Slow mode gives one step every other cycle, like a heavy axis
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos <= START;
      tick <= 1'b0;
    end
    else
    begin
      tick <= !tick;
      if (enc_step)
        pos <= enc_forward ? pos + 1 : pos - 1;
    end
  end
  assign enc_step = speed_cmd_ff != 16'h0000 && (!slow || tick);
  assign enc_forward = forward_ff;
  assign origin_sensor_input = pos >= ORG_LO && pos < ORG_HI;
  assign decel_sensor_input = pos >= DEC_LO && pos < ORG_LO;
  assign zphase_input = (pos % ZPITCH) == 0;
  assign pos_limit_input = pos >= LIM;
  assign neg_limit_input = pos <= -LIM;
endmodule : axis_model

// ---- verif/test_servo_homing_sequencer.sv ----
// Self-checking bench for the homing sequencer
`timescale 1ns/100ps
module test_servo_homing_sequencer;
  localparam int CPM = 10;
  logic        clk, rst, homing_start_input, panel_start, comm_start, servo_on, slow;
  logic        origin_sensor_input, decel_sensor_input, zphase_input, enc_step;
  logic        pos_limit_input, neg_limit_input, enc_forward;
  logic [2:0]  homing_start_source, limit_zphase_policy;
  logic [3:0]  homing_reference_mode;
  logic [15:0] search_high_speed, search_low_speed, search_ramp_time, homing_time_limit;
  logic [31:0] coordinate_offset, mechanical_offset, abs_position_ff;
  logic [15:0] speed_cmd_ff;
  logic        forward_ff, busy_ff, origin_found_ff, homing_done_ff;
  logic        homing_timeout_alarm_ff, limit_alarm_ff;
  int          mismatches, n_checks, n_found, i;
  servo_homing_sequencer #(.CYC_PER_MS(CPM)) servo_homing_sequencer_i (.clk, .rst,
    .homing_start_input, .panel_start, .comm_start, .servo_on, .origin_sensor_input,
    .decel_sensor_input, .zphase_input, .pos_limit_input, .neg_limit_input, .enc_step,
    .enc_forward, .homing_start_source, .homing_reference_mode, .limit_zphase_policy,
    .search_high_speed, .search_low_speed, .search_ramp_time, .homing_time_limit,
    .coordinate_offset, .mechanical_offset, .speed_cmd_ff, .forward_ff, .busy_ff,
    .origin_found_ff, .homing_done_ff, .homing_timeout_alarm_ff, .limit_alarm_ff,
    .abs_position_ff);
  axis_model axis_model_i (.clk, .rst, .slow, .speed_cmd_ff, .forward_ff, .enc_step,
    .enc_forward, .origin_sensor_input, .decel_sensor_input, .zphase_input,
    .pos_limit_input, .neg_limit_input);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk or posedge rst)
    if (rst)
      n_found <= 0;
    else if (origin_found_ff === 1'b1)
      n_found <= n_found + 1;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // 0 done, 1 timeout alarm, 2 limit alarm, 3 no start; axis starts at 10
  function automatic int outcome(input int s, input int m, input int p, input int l);
    if (s == 0 || m > 8)
      return 3;
    if (l != 0 && l < 5 && m < 6)
      return 1;
    if ((m == 3 || m == 5) && p > 2)
      return 2;
    return 0;
  endfunction : outcome
  task automatic kick(input int s);
    @(posedge clk);
    #1;
    case (s)
      1: homing_start_input = 1'b1;
      2: panel_start = 1'b1;
      3: comm_start = 1'b1;
      4: servo_on = 1'b1;
      default:
      begin
        homing_start_input = 1'b1;
        panel_start = 1'b1;
        comm_start = 1'b1;
        servo_on = 1'b1;
      end
    endcase
    @(posedge clk);
    #1;
    panel_start = 1'b0;
    comm_start = 1'b0;
    repeat (4) @(posedge clk);
    #1 homing_start_input = 1'b0;
  endtask : kick
  task automatic run(input int s, input int m, input int p, input int l, input int mech);
    int          e;
    int          got;
    logic [31:0] diff;
    logic        ok;
    rst = 1'b1;
    servo_on = 1'b0;
    homing_start_source = 3'(s);
    homing_reference_mode = 4'(m);
    limit_zphase_policy = 3'(p);
    homing_time_limit = 16'(l);
    mechanical_offset = 32'(mech);
    coordinate_offset = $urandom;
    search_high_speed = 16'($urandom_range(10, 2));
    search_low_speed = 16'($urandom_range(int'(search_high_speed) - 1, 1));
    slow = 1'($urandom_range(1, 0));
    search_ramp_time = 16'($urandom_range(2, 0));
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    e = outcome(s, m, p, l);
    kick(s);
    got = 3;
    for (int k = 0; k < (e == 3 ? 60 : 20000) && got == 3; k++)
    begin
      @(posedge clk);
      #1;
      if (homing_done_ff === 1'b1) got = 0;
      else if (homing_timeout_alarm_ff === 1'b1) got = 1;
      else if (limit_alarm_ff === 1'b1) got = 2;
    end
    check("outcome", 32'(got), 32'(e));
    check("busy", 32'(busy_ff), 32'h0000_0000);
    if (got == 0)
    begin
      check("found pulses", 32'(n_found), 32'h0000_0001);
      check("speed", 32'(speed_cmd_ff), 32'h0000_0000);
    end
    if (got == 0 && m == 8)
    begin
      diff = abs_position_ff - coordinate_offset;
      ok = mech == 0 ? diff == 0 : (mech > 0 ? $signed(diff) >= mech : $signed(diff) <= mech);
      check("offset move", 32'(ok), 32'h0000_0001);
    end
    $display("test src %0d mode %0d policy %0d limit %0d ended", s, m, p, l);
  endtask : run
  initial
  begin
    rst = 1'b1;
    homing_start_input = 1'b0;
    panel_start = 1'b0;
    comm_start = 1'b0;
    servo_on = 1'b0;
    slow = 1'b0;
    homing_start_source = 3'h0;
    homing_reference_mode = 4'h0;
    limit_zphase_policy = 3'h0;
    search_high_speed = 16'h0004;
    search_low_speed = 16'h0001;
    search_ramp_time = 16'h0001;
    homing_time_limit = 16'h01F4;
    coordinate_offset = 32'h0000_0000;
    mechanical_offset = 32'h0000_0000;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(32'h6a0e_d9e2));
    for (i = 0; i < 5; i++)
      run(i, 8, 0, 500, 0);
    // Only the first servo-on after reset may start homing
    servo_on = 1'b0;
    repeat (3) @(posedge clk);
    #1 servo_on = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("second servo on", 32'(busy_ff), 32'h0000_0000);
    check("done kept", 32'(homing_done_ff), 32'h0000_0001);
    for (i = 0; i < 10; i++)
      run(3, i, $urandom_range(5, 0), 500, 0);
    for (i = 0; i < 6; i++)
      run(3, 3, i, 500, 0);
    for (i = 3; i < 6; i++)
      run(3, 1, i, 500, 0);
    run(3, $urandom_range(5, 0), 0, $urandom_range(4, 2), 0);
    // Zero limit must never time out, even on a long search
    run(3, 2, 2, 0, 0);
    run(2, 8, 0, 500, 40);
    repeat (3)
      run(2, 8, 0, 500, int'($urandom_range(100, 0)) - 50);
    close_out();
  end
  initial
  begin
    #5_000_000;
    mismatches++;
    close_out();
  end
endmodule : test_servo_homing_sequencer
bind servo_homing_sequencer servo_homing_sequencer_assertions #(.CYC_PER_MS(CYC_PER_MS))
  chk_i (.clk, .rst, .panel_start, .comm_start, .homing_start_source,
  .homing_reference_mode, .search_high_speed, .search_ramp_time, .homing_time_limit,
  .coordinate_offset, .speed_cmd_ff, .forward_ff, .busy_ff, .origin_found_ff,
  .homing_done_ff, .homing_timeout_alarm_ff, .limit_alarm_ff, .abs_position_ff);
